// [logic/acs_params.svh]
// Constants of the actuator network status and control block.
// Assumes a 250 MHz core clock; included by the package and by acs_ctrl.
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// Clock and time base
`define ACS_CLK_MHZ 250
`define ACS_NS_PER_MS 1000000
`define ACS_CYC_PER_MS (`ACS_NS_PER_MS * `ACS_CLK_MHZ / 1000)

// Times in milliseconds, as printed
`define ACS_OVL_MS 15
`define ACS_GRACE_MS 10000
`define ACS_TOUT_MS 5000
`define ACS_FB_MS 100
// Overload needs a full 15 ms: one extra tick covers the partial first ms
`define ACS_OVL_TICKS 16'(`ACS_OVL_MS + 1)
`define ACS_GRACE_TICKS 16'(`ACS_GRACE_MS)
`define ACS_TOUT_RST 16'(`ACS_TOUT_MS)
`define ACS_FB_TICKS 16'(`ACS_FB_MS)

// Node identity and frame identifiers
`define ACS_NODE_BASE 7'h13
`define ACS_NMT_ID 11'h000
`define ACS_RPDO_BASE 11'h200
`define ACS_TPDO_BASE 11'h180
`define ACS_DLC_NMT 4'h2
`define ACS_DLC_FULL 4'h8

// Network management command specifiers
`define ACS_NMT_START 8'h01
`define ACS_NMT_STOP 8'h02
`define ACS_NMT_PREOP 8'h80
`define ACS_NMT_RST_NODE 8'h81
`define ACS_NMT_RST_COMM 8'h82
`define ACS_NMT_ALL 8'h00

// Field slices of a received frame (byte 0 in the low bits)
`define ACS_RX_CS 7:0
`define ACS_RX_NODE 15:8
`define ACS_RX_POS 15:0
`define ACS_RX_CUR 31:16
`define ACS_RX_SPD 39:32
`define ACS_RX_CTL 63:56
`define ACS_CTL_EN 0

// Error flag bits
`define ACS_ERR_PARAM 0
`define ACS_ERR_OVL 1
`define ACS_ERR_VOLT 2
`define ACS_ERR_TEMP 3
`define ACS_ERR_BACK 4
`define ACS_ERR_TOUT 5
`define ACS_ERR_FATAL 6
`define ACS_ERR_MEM 7

// Register offsets and reset values
`define ACS_REG_TOUT 8'h00
`define ACS_REG_LIMIT 8'h04
`define ACS_REG_MAXPOS 8'h08
`define ACS_REG_STATUS 8'h0C
`define ACS_REG_MEAS 8'h10
`define ACS_MAXCUR_RST 16'h0096
`define ACS_MAXSPD_RST 8'hFF
`define ACS_MAXPOS_RST 16'hFFFF
`define ACS_SYNC_WAIT 2'h3

`endif

// [logic/acs_pkg.sv]
// Types of the actuator network status and control block.
// Assumes acs_params.svh is on the include path.
`include "acs_params.svh"
package acs_pkg;

    // Network management slave states
    typedef enum logic [1:0] {NMT_INIT, NMT_PREOP, NMT_OPER, NMT_STOP}
        acs_nmt_e;

    // Whole state of the main module
    typedef struct packed {
        acs_nmt_e nmt;
        logic [1:0] init_cnt;
        logic [2:0] sel_m;
        logic [2:0] sel_s;
        logic [6:0] node;
        logic [15:0] tgt_pos;
        logic [15:0] tgt_cur;
        logic [7:0] tgt_spd;
        logic [7:0] ctl;
        logic [7:0] err;
        logic [2:0] mflg;
        logic run;
        logic [15:0] meas_cur;
        logic [15:0] meas_pos;
        logic [7:0] meas_spd;
        logic [17:0] ms_cnt;
        logic tick;
        logic tx_pend;
        logic [10:0] tx_id;
        logic [63:0] tx_data;
        logic [15:0] tout_ms;
        logic [15:0] max_cur;
        logic [15:0] max_pos;
        logic [7:0] max_spd;
        logic [31:0] rdata;
    } acs_state_s;

    // State of one millisecond timer
    typedef struct packed {
        logic [15:0] count;
    } acs_tmr_s;

endpackage : acs_pkg

// [logic/acs_tmr_if.sv]
// Control and result of one millisecond timer.
// Owner drives run, restart and limit; timer answers expired.
`timescale 1ns/10ps
interface acs_tmr_if;
    logic run;
    logic restart;
    logic [15:0] limit;
    logic expired;
    modport owner (output run, output restart, output limit, input expired);
    modport timer (input run, input restart, input limit, output expired);
endinterface : acs_tmr_if

// [logic/acs_ms_timer.sv]
// Millisecond timer: counts ticks while run, expires at limit.
// Assumes one tick pulse per millisecond from the same clock.
`timescale 1ns/10ps
module acs_ms_timer
    import acs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_tick,
    acs_tmr_if.timer t
);
    acs_tmr_s s_q;
    acs_tmr_s s_d;

    // Count holds at expiry so the flag stays up until released
    always_comb
    begin
        s_d = s_q;
        if (!t.run || t.restart)
        begin
            s_d.count = '0;
        end
        else if (i_tick && !t.expired)
        begin
            s_d.count = s_q.count + 16'h0001;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign t.expired = t.run && (s_q.count >= t.limit);

endmodule : acs_ms_timer

// [logic/acs_ctrl.sv]
// Network side of a linear actuator: control frame decode, network
// management, feedback fields, error flags and motion interlocks.
// Assumes a CAN controller that delivers whole frames, and motor side
// logic on the same clock that supplies measurements and fault levels.
`timescale 1ns/10ps
`include "acs_params.svh"
module acs_ctrl
    import acs_pkg::*;
#(
    parameter int P_CYC_PER_MS = `ACS_CYC_PER_MS
)
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic [2:0] i_addr_sel,
    input wire logic i_rx_valid,
    input wire logic i_rx_ide,
    input wire logic [10:0] i_rx_id,
    input wire logic [3:0] i_rx_dlc,
    input wire logic [63:0] i_rx_data,
    input wire logic i_tx_ready,
    output logic o_tx_valid,
    output logic [10:0] o_tx_id,
    output logic [63:0] o_tx_data,
    input wire logic i_pwm_on,
    input wire logic [15:0] i_meas_current,
    input wire logic [7:0] i_meas_speed,
    input wire logic [15:0] i_meas_pos,
    input wire logic i_extending,
    input wire logic i_retracting,
    input wire logic i_saturated,
    input wire logic i_volt_bad,
    input wire logic i_temp_bad,
    input wire logic i_backdrive,
    input wire logic i_stall,
    input wire logic i_mem_bad,
    input wire logic [7:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    output logic [31:0] o_reg_rdata,
    output logic o_motion_enable,
    output logic [15:0] o_target_pos,
    output logic [15:0] o_current_limit,
    output logic [7:0] o_target_speed,
    output logic [6:0] o_node_id,
    output acs_pkg::acs_nmt_e o_nmt_state,
    output logic [7:0] o_error_flags,
    output logic [2:0] o_motion_flags,
    output logic [15:0] o_meas_current
);
    import acs_pkg::*;

    acs_state_s s_q;
    acs_state_s s_d;

    acs_tmr_if t_ovl ();
    acs_tmr_if t_grace ();
    acs_tmr_if t_tout ();
    acs_tmr_if t_fb ();

    logic is_std;
    logic nmt_hit;
    logic rpdo_hit;
    logic range_bad;
    logic env_bad;
    logic lock;
    logic [7:0] err_set;
    logic [7:0] err_clr;

    // Frame classification; extended frames never match anything
    assign is_std = i_rx_valid && !i_rx_ide;
    assign nmt_hit = is_std && (i_rx_id == `ACS_NMT_ID)
        && (i_rx_dlc >= `ACS_DLC_NMT)
        && ((i_rx_data[`ACS_RX_NODE] == `ACS_NMT_ALL)
        || (i_rx_data[`ACS_RX_NODE] == {1'b0, s_q.node}));
    // Control frames count only when operational and full length
    assign rpdo_hit = is_std && (s_q.nmt == NMT_OPER)
        && (i_rx_id == (`ACS_RPDO_BASE + {4'h0, s_q.node}))
        && (i_rx_dlc == `ACS_DLC_FULL);
    // Model range check against the software limits
    assign range_bad = (i_rx_data[`ACS_RX_CUR] > s_q.max_cur)
        || (i_rx_data[`ACS_RX_SPD] > s_q.max_spd)
        || (i_rx_data[`ACS_RX_POS] > s_q.max_pos);

    // Interlocks: supply and temperature stop new starts; parameter, overload and fatal errors or leaving operational forbid any motion outright
    assign env_bad = s_q.err[`ACS_ERR_VOLT] || s_q.err[`ACS_ERR_TEMP];
    assign lock = (s_q.nmt != NMT_OPER)
        || s_q.err[`ACS_ERR_PARAM]
        || s_q.err[`ACS_ERR_OVL]
        || s_q.err[`ACS_ERR_FATAL];

    // Timer hookup: each timer is tied to the condition it measures
    assign t_ovl.run = s_q.run && (s_q.meas_cur > s_q.tgt_cur);
    assign t_ovl.restart = 1'b0;
    assign t_ovl.limit = `ACS_OVL_TICKS;
    assign t_grace.run = s_q.run && env_bad;
    assign t_grace.restart = 1'b0;
    assign t_grace.limit = `ACS_GRACE_TICKS;
    assign t_tout.run = (s_q.nmt == NMT_OPER);
    assign t_tout.restart = rpdo_hit;
    assign t_tout.limit = s_q.tout_ms;
    assign t_fb.run = (s_q.nmt == NMT_OPER);
    assign t_fb.restart = t_fb.expired;
    assign t_fb.limit = `ACS_FB_TICKS;

    // Error events, sticky but for supply and temperature; set beats clear in the same cycle
    always_comb
    begin
        err_set = '0;
        err_clr = '0;
        err_set[`ACS_ERR_PARAM] = rpdo_hit && range_bad;
        err_clr[`ACS_ERR_PARAM] = rpdo_hit && !range_bad;
        err_set[`ACS_ERR_OVL] = t_ovl.expired;
        err_clr[`ACS_ERR_OVL] = !s_q.ctl[`ACS_CTL_EN];
        err_set[`ACS_ERR_VOLT] = i_volt_bad;
        err_clr[`ACS_ERR_VOLT] = !i_volt_bad;
        err_set[`ACS_ERR_TEMP] = i_temp_bad;
        err_clr[`ACS_ERR_TEMP] = !i_temp_bad;
        err_set[`ACS_ERR_BACK] = i_backdrive && !s_q.run;
        err_clr[`ACS_ERR_BACK] = rpdo_hit;
        // A frame restarts the count, so expiry seen beside it is stale
        err_set[`ACS_ERR_TOUT] = t_tout.expired && !t_tout.restart;
        err_clr[`ACS_ERR_TOUT] = rpdo_hit;
        err_set[`ACS_ERR_FATAL] = i_stall && s_q.run;
        err_clr[`ACS_ERR_FATAL] = !s_q.ctl[`ACS_CTL_EN];
        err_set[`ACS_ERR_MEM] = i_mem_bad;
    end

    // Next state of the whole block
    always_comb
    begin
        s_d = s_q;

        // Address selects are pins: two flops before use
        s_d.sel_m = i_addr_sel;
        s_d.sel_s = s_q.sel_m;

        // Millisecond tick for the timers
        s_d.tick = 1'b0;
        if (s_q.ms_cnt == 18'(P_CYC_PER_MS - 1))
        begin
            s_d.ms_cnt = '0;
            s_d.tick = 1'b1;
        end
        else
        begin
            s_d.ms_cnt = s_q.ms_cnt + 18'h00001;
        end

        // Measurements; current only valid while drive is on
        if (i_pwm_on)
        begin
            s_d.meas_cur = i_meas_current;
        end
        s_d.meas_spd = i_meas_speed;
        s_d.meas_pos = i_meas_pos;
        s_d.mflg = {i_saturated, i_retracting, i_extending};

        // Network management slave
        case (s_q.nmt)
            NMT_INIT:
            begin
                // Wait for the synchroniser to fill before taking the strap
                s_d.ctl = '0;
                if (s_q.init_cnt == `ACS_SYNC_WAIT)
                begin
                    s_d.node = `ACS_NODE_BASE + 7'(s_q.sel_s);
                    s_d.nmt = NMT_PREOP;
                end
                else
                begin
                    s_d.init_cnt = s_q.init_cnt + 2'h1;
                end
            end
            NMT_PREOP, NMT_OPER, NMT_STOP:
            begin
                if (nmt_hit)
                begin
                    case (i_rx_data[`ACS_RX_CS])
                        `ACS_NMT_START: s_d.nmt = NMT_OPER;
                        `ACS_NMT_STOP: s_d.nmt = NMT_STOP;
                        `ACS_NMT_PREOP: s_d.nmt = NMT_PREOP;
                        `ACS_NMT_RST_NODE, `ACS_NMT_RST_COMM:
                        begin
                            s_d.nmt = NMT_INIT;
                            s_d.init_cnt = '0;
                        end
                        default: s_d.nmt = s_q.nmt;
                    endcase
                end
            end
            default:
            begin
                s_d.nmt = NMT_INIT;
                s_d.init_cnt = '0;
            end
        endcase

        // Control frame: store fields even when the enable bit is low
        if (rpdo_hit)
        begin
            s_d.tgt_pos = i_rx_data[`ACS_RX_POS];
            s_d.tgt_cur = i_rx_data[`ACS_RX_CUR];
            s_d.tgt_spd = i_rx_data[`ACS_RX_SPD];
            s_d.ctl = i_rx_data[`ACS_RX_CTL];
        end

        s_d.err = (s_q.err & ~err_clr) | err_set;

        // Motion gate: new starts need a clean state, a running move
        // may ride out a supply or temperature fault for the grace time
        s_d.run = s_q.ctl[`ACS_CTL_EN] && !lock
            && (!env_bad || (s_q.run && !t_grace.expired));

        // Feedback frame; a period that finds one still pending is
        // skipped rather than queued, so the bus sees no burst
        if (s_q.tx_pend && i_tx_ready)
        begin
            s_d.tx_pend = 1'b0;
        end
        if (t_fb.expired && !s_q.tx_pend)
        begin
            s_d.tx_pend = 1'b1;
            s_d.tx_id = `ACS_TPDO_BASE + {4'h0, s_q.node};
            s_d.tx_data = {s_q.err, 8'(s_q.mflg), 8'h00, s_q.meas_spd,
                s_q.meas_cur, s_q.meas_pos};
        end

        // Register writes
        if (i_reg_wr)
        begin
            case (i_reg_addr)
                `ACS_REG_TOUT: s_d.tout_ms = i_reg_wdata[15:0];
                `ACS_REG_LIMIT:
                begin
                    s_d.max_cur = i_reg_wdata[15:0];
                    s_d.max_spd = i_reg_wdata[23:16];
                end
                `ACS_REG_MAXPOS: s_d.max_pos = i_reg_wdata[15:0];
                default: s_d.tout_ms = s_q.tout_ms;
            endcase
        end

        // Register reads: data only in the cycle after the strobe
        s_d.rdata = '0;
        if (i_reg_rd)
        begin
            case (i_reg_addr)
                `ACS_REG_TOUT: s_d.rdata = {16'h0000, s_q.tout_ms};
                `ACS_REG_LIMIT:
                    s_d.rdata = {8'h00, s_q.max_spd, s_q.max_cur};
                `ACS_REG_MAXPOS: s_d.rdata = {16'h0000, s_q.max_pos};
                `ACS_REG_STATUS:
                    s_d.rdata = {1'b0, s_q.node, 6'h00, s_q.nmt, 5'h00,
                        s_q.mflg, s_q.err};
                `ACS_REG_MEAS:
                    s_d.rdata = {8'h00, s_q.meas_spd, s_q.meas_cur};
                default: s_d.rdata = '0;
            endcase
        end
    end

    // State register with synchronous reset
    always_ff @(posedge i_clock)
    begin
        if (!i_rstn)
        begin
            s_q <= '0;
            s_q.nmt <= NMT_INIT;
            s_q.node <= `ACS_NODE_BASE;
            s_q.tout_ms <= `ACS_TOUT_RST;
            s_q.max_cur <= `ACS_MAXCUR_RST;
            s_q.max_spd <= `ACS_MAXSPD_RST;
            s_q.max_pos <= `ACS_MAXPOS_RST;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Timers share one tick so all periods stay in step
    acs_ms_timer u_tmr_ovl (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(s_q.tick),
        .t(t_ovl)
    );

    acs_ms_timer u_tmr_grace (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(s_q.tick),
        .t(t_grace)
    );

    acs_ms_timer u_tmr_tout (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(s_q.tick),
        .t(t_tout)
    );

    acs_ms_timer u_tmr_fb (
        .i_clock(i_clock),
        .i_rstn(i_rstn),
        .i_tick(s_q.tick),
        .t(t_fb)
    );

    // Outputs straight from the state register
    assign o_tx_valid = s_q.tx_pend;
    assign o_tx_id = s_q.tx_id;
    assign o_tx_data = s_q.tx_data;
    assign o_reg_rdata = s_q.rdata;
    assign o_motion_enable = s_q.run;
    assign o_target_pos = s_q.tgt_pos;
    assign o_current_limit = s_q.tgt_cur;
    assign o_target_speed = s_q.tgt_spd;
    assign o_node_id = s_q.node;
    assign o_nmt_state = s_q.nmt;
    assign o_error_flags = s_q.err;
    assign o_motion_flags = s_q.mflg;
    assign o_meas_current = s_q.meas_cur;

endmodule : acs_ctrl

// [bench/acs_ctrl_props.sv]
// Checker of the actuator status and control block, top ports only.
// Assumes one clock domain and the synchronous active low reset.
`timescale 1ns/10ps
module acs_ctrl_props
    import acs_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_tx_ready,
    input wire logic o_tx_valid,
    input wire logic [10:0] o_tx_id,
    input wire logic [63:0] o_tx_data,
    input wire logic i_pwm_on,
    input wire logic [15:0] i_meas_current,
    input wire logic i_extending,
    input wire logic i_retracting,
    input wire logic i_saturated,
    input wire logic i_volt_bad,
    input wire logic i_temp_bad,
    input wire logic i_stall,
    input wire logic i_mem_bad,
    input wire logic o_motion_enable,
    input wire logic [6:0] o_node_id,
    input wire acs_nmt_e o_nmt_state,
    input wire logic [7:0] o_error_flags,
    input wire logic [2:0] o_motion_flags,
    input wire logic [15:0] o_meas_current
);
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rstn);

    // Feedback frame waiting for the controller
    sequence s_wait;
        o_tx_valid && !i_tx_ready;
    endsequence
    sequence s_keep;
        o_tx_valid && $stable(o_tx_data) && $stable(o_tx_id);
    endsequence

    property p_rst;
        @(posedge i_clock) disable iff (1'b0)
        !i_rstn |=> o_nmt_state == NMT_INIT && o_error_flags == 8'h00
            && !o_motion_enable;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    // Past reset guard: the first edge still shows reset values
    property p_mflg;
        $past(i_rstn) |-> o_motion_flags ==
            $past({i_saturated, i_retracting, i_extending});
    endproperty
    a_mflg: assert property (p_mflg) else $error("motion flags");
    property p_env;
        $past(i_rstn) |-> o_error_flags[2] == $past(i_volt_bad)
            && o_error_flags[3] == $past(i_temp_bad);
    endproperty
    a_env: assert property (p_env) else $error("env flags");
    property p_mem;
        (i_mem_bad || o_error_flags[7]) |=> o_error_flags[7];
    endproperty
    a_mem: assert property (p_mem) else $error("memory flag");
    property p_stall;
        i_stall && o_motion_enable |-> ##[1:2] o_error_flags[6];
    endproperty
    a_stall: assert property (p_stall) else $error("fatal flag");
    property p_block;
        (o_error_flags[0] || o_error_flags[1] || o_error_flags[6])
            |=> !o_motion_enable;
    endproperty
    a_block: assert property (p_block) else $error("err motion");
    property p_oper;
        o_motion_enable |-> $past(o_nmt_state) == NMT_OPER;
    endproperty
    a_oper: assert property (p_oper) else $error("not oper");
    property p_node;
        o_nmt_state != NMT_INIT |-> o_node_id >= 7'h13 && o_node_id <= 7'h1A;
    endproperty
    a_node: assert property (p_node) else $error("node range");
    property p_tx_hold;
        s_wait |=> s_keep;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx dropped");
    property p_tx_id;
        o_tx_valid |-> o_tx_id == 11'h180 + {4'h0, o_node_id};
    endproperty
    a_tx_id: assert property (p_tx_id) else $error("tx id");
    // Current is taken only in drive on-time, otherwise held
    property p_cur;
        1'b1 |=> o_meas_current == ($past(i_pwm_on) ?
            $past(i_meas_current) : $past(o_meas_current));
    endproperty
    a_cur: assert property (p_cur) else $error("measured current");
endmodule : acs_ctrl_props

// [bench/acs_can_host.sv]
// Host CAN controller model: sends frames, takes feedback frames.
// Assumes the device samples its receive side on rising edges.
`timescale 1ns/10ps
module acs_can_host
(
    input wire logic i_clock,
    input wire logic i_tx_valid,
    input wire logic [63:0] i_tx_data,
    output logic o_rx_valid,
    output logic o_rx_ide,
    output logic [10:0] o_rx_id,
    output logic [3:0] o_rx_dlc,
    output logic [63:0] o_rx_data,
    output logic o_tx_ready
);
    int stall = 0;
    int got = 0;
    int wait_n = 0;
    logic [63:0] last = 64'h0;
    initial
    begin
        {o_rx_valid, o_rx_ide, o_rx_id, o_rx_dlc, o_rx_data} = '0;
        o_tx_ready = 1'b0;
    end
    // One frame for one cycle; id and data lines then show inverted junk
    task automatic send(input logic ide, input logic [10:0] id,
        input logic [3:0] dlc, input logic [63:0] d);
        @(posedge i_clock);
        o_rx_valid <= 1'b1;
        o_rx_ide <= ide;
        o_rx_id <= id;
        o_rx_dlc <= dlc;
        o_rx_data <= d;
        @(posedge i_clock);
        o_rx_valid <= 1'b0;
        o_rx_id <= ~id;
        o_rx_data <= ~d;
    endtask : send
    // Slow acceptor: ready only after stall cycles of valid
    always @(posedge i_clock)
    begin
        if (i_tx_valid && o_tx_ready)
        begin
            last <= i_tx_data;
            got <= got + 1;
            o_tx_ready <= 1'b0;
            wait_n <= 0;
        end
        else if (i_tx_valid)
        begin
            wait_n <= wait_n + 1;
            o_tx_ready <= (wait_n >= stall);
        end
    end
endmodule : acs_can_host

// [bench/actuator_can_status_control_test.sv]
// Self-checking bench of the actuator status and control block.
// Assumes design, checker and host model are compiled before it.
`timescale 1ns/10ps
module actuator_can_status_control_test;
    import acs_pkg::*;
    typedef struct packed {
        logic ide;
        logic [10:0] id;
        logic [3:0] dlc;
        logic [63:0] d;
        logic [1:0] nmt;
        logic en;
    } acs_row_s;
    localparam logic [63:0] RUN = 64'h0100004000501234;
    localparam logic [63:0] HOLD = 64'h0000004000501234;
    logic i_clock, i_rstn, i_rx_valid, i_rx_ide, i_tx_ready, i_pwm_on;
    logic i_extending, i_retracting, i_saturated, i_volt_bad, i_temp_bad;
    logic i_backdrive, i_stall, i_mem_bad, i_reg_wr, i_reg_rd;
    logic o_tx_valid, o_motion_enable;
    logic [2:0] i_addr_sel, o_motion_flags;
    logic [10:0] i_rx_id, o_tx_id;
    logic [3:0] i_rx_dlc;
    logic [63:0] i_rx_data, o_tx_data;
    logic [15:0] i_meas_current, i_meas_pos, o_target_pos;
    logic [15:0] o_current_limit, o_meas_current;
    logic [7:0] i_meas_speed, i_reg_addr, o_target_speed, o_error_flags;
    logic [31:0] i_reg_wdata, o_reg_rdata;
    logic [6:0] o_node_id;
    acs_nmt_e o_nmt_state;
    int failures = 0;
    int samples_checked = 0;
    int n;
    time t0;
    // Frames in order, with the state and enable each should leave
    acs_row_s rows [12] = '{
        '{1'b0, 11'h000, 4'h2, 64'h1501, 2'h1, 1'b0},
        '{1'b0, 11'h213, 4'h8, RUN, 2'h1, 1'b0},
        '{1'b0, 11'h000, 4'h2, 64'h0001, 2'h2, 1'b0},
        '{1'b1, 11'h213, 4'h8, RUN, 2'h2, 1'b0},
        '{1'b0, 11'h214, 4'h8, RUN, 2'h2, 1'b0},
        '{1'b0, 11'h213, 4'h7, RUN, 2'h2, 1'b0},
        '{1'b0, 11'h213, 4'h8, RUN, 2'h2, 1'b1},
        '{1'b0, 11'h213, 4'h8, HOLD, 2'h2, 1'b0},
        '{1'b0, 11'h000, 4'h2, 64'h1302, 2'h3, 1'b0},
        '{1'b0, 11'h000, 4'h2, 64'h1380, 2'h1, 1'b0},
        '{1'b0, 11'h000, 4'h2, 64'h1301, 2'h2, 1'b0},
        '{1'b0, 11'h213, 4'h8, RUN, 2'h2, 1'b1}};

    acs_ctrl #(.P_CYC_PER_MS(10)) uut (.*);
    acs_can_host host (.i_clock(i_clock), .i_tx_valid(o_tx_valid),
        .i_tx_data(o_tx_data), .o_rx_valid(i_rx_valid),
        .o_rx_ide(i_rx_ide), .o_rx_id(i_rx_id), .o_rx_dlc(i_rx_dlc),
        .o_rx_data(i_rx_data), .o_tx_ready(i_tx_ready));

    task automatic end_sim;
        $display("failures=%0d samples_checked=%0d", failures,
            samples_checked);
        if (failures == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        samples_checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // Let frame, state and enable updates land before sampling
    task automatic settle;
        repeat (3) @(posedge i_clock);
        #1;
    endtask : settle
    task automatic fr(input logic [63:0] d);
        host.send(1'b0, 11'h213, 4'h8, d);
        settle();
    endtask : fr
    task automatic reset;
        @(posedge i_clock);
        i_rstn <= 1'b0;
        repeat (8) @(posedge i_clock);
        i_rstn <= 1'b1;
        repeat (10) @(posedge i_clock);
        #1;
    endtask : reset
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_wr <= 1'b1;
        @(posedge i_clock);
        i_reg_wr <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clock);
        i_reg_addr <= a;
        i_reg_rd <= 1'b1;
        @(posedge i_clock);
        i_reg_rd <= 1'b0;
        #1;
        chk(o_reg_rdata, e);
    endtask : rc
    task automatic wait_got(input int g);
        for (int c = 0; c < 1500 && host.got < g; c++)
        begin
            @(posedge i_clock);
            #1;
        end
        chk(host.got, g);
    endtask : wait_got

    initial
    begin
        i_clock = 1'b0;
        forever #2 i_clock = ~i_clock;
    end
    // Whole run is near 2600 cycles; give it over fourteen times that
    initial
    begin
        #150000;
        failures++;
        end_sim();
    end
    initial
    begin
        {i_rstn, i_addr_sel, i_pwm_on, i_meas_current, i_meas_speed} = '0;
        {i_meas_pos, i_extending, i_retracting, i_saturated} = '0;
        {i_volt_bad, i_temp_bad, i_backdrive, i_stall, i_mem_bad} = '0;
        {i_reg_addr, i_reg_wdata, i_reg_wr, i_reg_rd} = '0;
        for (int a = 7; a >= 0; a--)
        begin
            i_addr_sel <= 3'(a);
            reset();
            chk(o_node_id, 7'h13 + 7'(a));
            chk(o_nmt_state, NMT_PREOP);
        end
        foreach (rows[k])
        begin
            host.send(rows[k].ide, rows[k].id, rows[k].dlc, rows[k].d);
            settle();
            chk(o_nmt_state, rows[k].nmt);
            chk(o_motion_enable, rows[k].en);
        end
        chk({o_target_pos, o_current_limit, o_target_speed},
            40'h1234005040);
        // Feedback with a controller that stalls four cycles
        i_pwm_on <= 1'b1;
        i_meas_current <= 16'h0033;
        i_meas_speed <= 8'h2A;
        i_meas_pos <= 16'h0777;
        i_extending <= 1'b1;
        host.stall = 4;
        n = host.got;
        wait_got(n + 1);
        t0 = $time;
        wait_got(n + 2);
        chk(($time - t0) / 4, 1000);
        chk(host.last, 64'h0001002A00330777);
        rc(8'h00, 32'h00001388);
        rc(8'h04, 32'h00FF0096);
        rc(8'h08, 32'h0000FFFF);
        rc(8'h20, 32'h00000000);
        wr(8'h0C, 32'hFFFFFFFF);
        rc(8'h0C, 32'h13020100);
        wr(8'h00, 32'h00000003);
        fr(RUN);
        repeat (50) @(posedge i_clock);
        #1;
        chk(o_error_flags[5], 1'b1);
        fr(RUN);
        chk(o_error_flags[5], 1'b0);
        fr(64'h0100004001001234);
        chk({o_error_flags[0], o_motion_enable}, 2'b10);
        fr(RUN);
        chk({o_error_flags[0], o_motion_enable}, 2'b01);
        // Overload must wait a full 15 ms of excess current
        i_meas_current <= 16'h0060;
        repeat (140) @(posedge i_clock);
        #1;
        chk(o_error_flags[1], 1'b0);
        repeat (60) @(posedge i_clock);
        #1;
        chk({o_error_flags[1], o_motion_enable}, 2'b10);
        fr(RUN);
        chk(o_motion_enable, 1'b0);
        i_meas_current <= 16'h0010;
        fr(HOLD);
        chk(o_error_flags[1], 1'b0);
        fr(RUN);
        chk(o_motion_enable, 1'b1);
        i_stall <= 1'b1;
        @(posedge i_clock);
        i_stall <= 1'b0;
        settle();
        chk({o_error_flags[6], o_motion_enable}, 2'b10);
        fr(HOLD);
        fr(RUN);
        chk({o_error_flags[6], o_motion_enable}, 2'b01);
        i_volt_bad <= 1'b1;
        settle();
        chk({o_error_flags[2], o_motion_enable}, 2'b11);
        fr(HOLD);
        fr(RUN);
        chk(o_motion_enable, 1'b0);
        i_volt_bad <= 1'b0;
        i_temp_bad <= 1'b1;
        fr(RUN);
        chk({o_error_flags[3], o_motion_enable}, 2'b10);
        i_temp_bad <= 1'b0;
        fr(RUN);
        chk(o_motion_enable, 1'b1);
        fr(HOLD);
        i_backdrive <= 1'b1;
        @(posedge i_clock);
        i_backdrive <= 1'b0;
        settle();
        chk(o_error_flags[4], 1'b1);
        fr(RUN);
        chk(o_error_flags[4], 1'b0);
        i_mem_bad <= 1'b1;
        @(posedge i_clock);
        i_mem_bad <= 1'b0;
        fr(RUN);
        chk(o_error_flags[7], 1'b1);
        // Node reset: init for four cycles, then pre-operational again
        host.send(1'b0, 11'h000, 4'h2, 64'h1381);
        settle();
        chk(o_nmt_state, NMT_INIT);
        settle();
        chk({o_nmt_state, o_node_id}, {NMT_PREOP, 7'h13});
        end_sim();
    end
endmodule : actuator_can_status_control_test

bind acs_ctrl acs_ctrl_props u_props (.*);
